//--- tip_pkg.sv
// Package of constants and types for the transmit interpolation path.
package tip_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [6:0] TIP_ADDR_CLK_MULT    = 7'h06;
  localparam logic [6:0] TIP_ADDR_FILTER_CTRL = 7'h07;
  localparam logic [6:0] TIP_ADDR_STATUS      = 7'h08;
  localparam logic [7:0] TIP_RST_FILTER_CTRL  = 8'h10;
  localparam logic [1:0] TIP_RST_CLK_MULT     = 2'h3;
  localparam int         TIP_MODE_MSB         = 7;
  localparam int         TIP_MODE_LSB         = 4;

  // ----------------------------------------------------------------
  // Filter modes and figures
  // ----------------------------------------------------------------
  typedef enum logic [3:0]
  {
    TIP_MODE_PASS     = 4'h0,
    TIP_MODE_LOWPASS  = 4'h1,
    TIP_MODE_BANDPASS = 4'h5
  } tip_mode_e;

  localparam int         TIP_SAMPLE_W  = 10;
  localparam int         TIP_ACC_W     = 24;
  localparam int         TIP_LATENCY   = 30;
  localparam int         TIP_FLUSH     = 48;
  localparam int         TIP_PEAK_TAP  = TIP_LATENCY - 1;
  localparam int         TIP_TAPS      = TIP_FLUSH - 1;
  localparam int         TIP_HALF_SPAN = 17;
  localparam int         TIP_SHIFT     = 6;
  localparam logic signed [7:0] TIP_CENTER = 8'sh40;
  localparam int         TIP_FIFO_DEPTH = 16;
  localparam int         TIP_FRAME_BITS = 16;

  // ----------------------------------------------------------------
  // Serial frame: read flag, address, data, sent MSB first
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic       rd;
    logic [6:0] addr;
    logic [7:0] data;
  } tip_frame_s;

endpackage : tip_pkg

//--- tip_tx_path.sv
// Transmit interpolation path: serial registers, sample FIFO and 2x interpolator.
`timescale 1ns/100ps

// How it works
// RL1: The filter upsamples by two in low-pass or band-pass mode as chosen by software.
// RL2: Bits 7 to 4 of register 7 pick the mode, 0x1 for low-pass and 0x5 for band-pass.
// RL3: Any other mode value passes samples straight to the DAC with no filtering.
// RL4: An impulse written in an upsampling mode peaks at the DAC 30 update cycles later.
// RL5: In an upsampling mode the response to an impulse is back to zero 48 update cycles later.
// RL6: The DAC update rate is the reference rate times a programmed 1, 2, 4 or 8.
// RL7: While interpolating, the host gives one sample per two DAC updates.
// RL8: While bypassed, the host gives one sample per DAC update.
// RL9: The host clocks samples at the reference rate with any phase.
// RL10: Band-pass output is the low-pass output with every other sample negated.

// ----------------------------------------------------------------
// Dual-clock FIFO with gray-coded pointers
// ----------------------------------------------------------------
module tip_async_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  input  wire logic             i_wr_clk,
  input  wire logic             i_wr_rst,
  input  wire logic             i_wr_valid,
  input  wire logic [WIDTH-1:0] i_wr_data,
  output      logic             o_wr_ready,
  input  wire logic             i_rd_clk,
  input  wire logic             i_rd_rst,
  output      logic             o_rd_valid,
  input  wire logic             i_rd_ready,
  output      logic [WIDTH-1:0] o_rd_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wbin, wgray, rbin, rgray;
  logic [AW:0]      rg_meta, rg_sync, wg_meta, wg_sync;
  wire              push       = i_wr_valid & o_wr_ready;
  wire              pop        = i_rd_ready & o_rd_valid;
  wire [AW:0]       next_wbin  = wbin + (AW+1)'(push);
  wire [AW:0]       next_rbin  = rbin + (AW+1)'(pop);
  wire [AW:0]       next_wgray = next_wbin ^ (next_wbin >> 1);
  wire [AW:0]       next_rgray = next_rbin ^ (next_rbin >> 1);
  wire [AW:0]       full_gray  = {~rg_sync[AW:AW-1], rg_sync[AW-2:0]};

  assign o_rd_data = mem[rbin[AW-1:0]];

  always_ff @(posedge i_wr_clk)
  begin
    if (push)
      mem[wbin[AW-1:0]] <= i_wr_data;
  end

  always_ff @(posedge i_wr_clk)
  begin
    if (i_wr_rst)
    begin
      wbin <= '0; wgray <= '0; rg_meta <= '0; rg_sync <= '0; o_wr_ready <= 1'b0;
    end
    else
    begin
      wbin       <= next_wbin;
      wgray      <= next_wgray;
      rg_meta    <= rgray;
      rg_sync    <= rg_meta;
      o_wr_ready <= (next_wgray != full_gray);
    end
  end

  always_ff @(posedge i_rd_clk)
  begin
    if (i_rd_rst)
    begin
      rbin <= '0; rgray <= '0; wg_meta <= '0; wg_sync <= '0; o_rd_valid <= 1'b0;
    end
    else
    begin
      rbin       <= next_rbin;
      rgray      <= next_rgray;
      wg_meta    <= wgray;
      wg_sync    <= wg_meta;
      o_rd_valid <= (next_rgray != wg_sync);
    end
  end

  no_push_full_a: assert property (@(posedge i_wr_clk) disable iff (i_wr_rst)
    o_wr_ready |-> wgray != full_gray) else $error("FIFO ready while full");
  no_pop_empty_a: assert property (@(posedge i_rd_clk) disable iff (i_rd_rst)
    o_rd_valid |-> rgray != wg_sync) else $error("FIFO valid while empty");
endmodule : tip_async_fifo

// ----------------------------------------------------------------
// Top: transmit path
// ----------------------------------------------------------------
module tip_tx_path
  import tip_pkg::*;
(
  input  wire logic                    I_CLK_SYS,
  input  wire logic                    I_SRST,
  input  wire logic                    I_TX_SAMPLE_CLOCK,
  input  wire logic                    I_TX_ENABLE,
  input  wire logic [TIP_SAMPLE_W-1:0] I_SHARED_SAMPLE_PORT,
  input  wire logic                    I_SER_EN_N,
  input  wire logic                    I_SER_SCLK,
  input  wire logic                    I_SER_SDATA,
  output      logic                    O_SER_SDO,
  output      logic                    O_TX_READY,
  output      logic                    O_DAC_UPDATE,
  output      logic [TIP_SAMPLE_W-1:0] O_DAC_CODE
);
  // Symmetric half-band taps; even offsets other than the centre are zero.
  function automatic logic signed [7:0] coef(input int k);
    int off;
    off = (k > TIP_PEAK_TAP) ? k - TIP_PEAK_TAP : TIP_PEAK_TAP - k;
    if (off == 0)
      return TIP_CENTER;
    if (off > TIP_HALF_SPAN || off % 2 == 0)
      return 8'sh00;
    case (off)
      1:       return 8'sh27;
      3:       return -8'sh0c;
      5:       return 8'sh06;
      7:       return -8'sh03;
      9:       return 8'sh02;
      11:      return -8'sh01;
      13:      return 8'sh01;
      15:      return -8'sh01;
      default: return 8'sh01;
    endcase
  endfunction : coef

  function automatic logic signed [TIP_SAMPLE_W-1:0] sat(input logic signed [TIP_ACC_W-1:0] v);
    if (v > TIP_ACC_W'(signed'(10'sh1ff)))
      return 10'sh1ff;
    if (v < TIP_ACC_W'(signed'(-10'sh200)))
      return -10'sh200;
    return v[TIP_SAMPLE_W-1:0];
  endfunction : sat

  // ----------------------------------------------------------------
  // Link clock domain: sample capture
  // ----------------------------------------------------------------
  logic                    lrst_meta, lrst;
  logic                    link_valid;
  logic [TIP_SAMPLE_W-1:0] link_data;

  always_ff @(posedge I_TX_SAMPLE_CLOCK)
  begin
    lrst_meta <= I_SRST;
    lrst      <= lrst_meta;
  end

  // Samples are taken on the host's clock, whatever its phase to ours.
  always_ff @(posedge I_TX_SAMPLE_CLOCK)
  begin
    if (lrst)
      link_valid <= 1'b0;
    else
      link_valid <= I_TX_ENABLE; // RL9
    link_data <= I_SHARED_SAMPLE_PORT;
  end

  logic                    pop_valid;
  logic [TIP_SAMPLE_W-1:0] pop_data;
  wire                     pop;

  tip_async_fifo #(.WIDTH(TIP_SAMPLE_W), .DEPTH(TIP_FIFO_DEPTH)) u_fifo (
    .i_wr_clk   (I_TX_SAMPLE_CLOCK),
    .i_wr_rst   (lrst),
    .i_wr_valid (link_valid),
    .i_wr_data  (link_data),
    .o_wr_ready (O_TX_READY),
    .i_rd_clk   (I_CLK_SYS),
    .i_rd_rst   (I_SRST),
    .o_rd_valid (pop_valid),
    .i_rd_ready (pop),
    .o_rd_data  (pop_data)
  );

  // ----------------------------------------------------------------
  // Serial register port
  // ----------------------------------------------------------------
  logic [2:0]  ser_meta, ser_sync;
  logic        sclk_d;
  logic [14:0] shift;
  logic [4:0]  bit_cnt;
  logic [7:0]  rd_shift;
  logic [7:0]  filter_ctrl;
  logic [1:0]  mult_code;

  wire         ser_active = ~ser_sync[2];
  wire         sclk_rise  = ser_active & ser_sync[1] & ~sclk_d;
  wire         sclk_fall  = ser_active & ~ser_sync[1] & sclk_d;
  tip_frame_s  frame;
  assign       frame      = {shift, ser_sync[0]};
  wire [6:0]   head_addr  = {shift[5:0], ser_sync[0]};
  wire         head_rd    = shift[6];
  wire         wr_commit  = sclk_rise & (bit_cnt == 5'(TIP_FRAME_BITS - 1)) & ~frame.rd;
  wire         head_done  = sclk_rise & (bit_cnt == 5'd7);

  wire [3:0]   mode       = filter_ctrl[TIP_MODE_MSB:TIP_MODE_LSB];
  wire         is_lp      = (mode == TIP_MODE_LOWPASS);  // RL2
  wire         is_bp      = (mode == TIP_MODE_BANDPASS); // RL2
  wire         interp_on  = is_lp | is_bp;               // RL1
  wire [7:0]   status     = {4'h0, mult_code, interp_on, ~pop_valid};
  wire [7:0]   rd_data    = (head_addr == TIP_ADDR_FILTER_CTRL) ? filter_ctrl :
                            (head_addr == TIP_ADDR_CLK_MULT)    ? {6'h00, mult_code} :
                            (head_addr == TIP_ADDR_STATUS)      ? status : 8'h00;

  always_ff @(posedge I_CLK_SYS)
  begin
    ser_meta <= {I_SER_EN_N, I_SER_SCLK, I_SER_SDATA};
    ser_sync <= ser_meta;
    sclk_d   <= ser_sync[1];
  end

  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_SRST || !ser_active)
      bit_cnt <= '0;
    else if (sclk_rise)
      bit_cnt <= bit_cnt + 5'd1;
    if (sclk_rise)
      shift <= frame[14:0];
  end

  // Read data leaves on falling edges so the host samples it on rising ones.
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_SRST)
    begin
      rd_shift  <= '0;
      O_SER_SDO <= 1'b0;
    end
    else if (head_done)
      rd_shift <= head_rd ? rd_data : 8'h00;
    else if (sclk_fall && bit_cnt >= 5'd8)
    begin
      O_SER_SDO <= rd_shift[7];
      rd_shift  <= {rd_shift[6:0], 1'b0};
    end
  end

  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_SRST)
    begin
      filter_ctrl <= TIP_RST_FILTER_CTRL;
      mult_code   <= TIP_RST_CLK_MULT;
    end
    else if (wr_commit && frame.addr == TIP_ADDR_FILTER_CTRL)
      filter_ctrl <= frame.data; // RL2
    else if (wr_commit && frame.addr == TIP_ADDR_CLK_MULT)
      mult_code <= frame.data[1:0]; // RL6
  end

  // ----------------------------------------------------------------
  // DAC update strobe and interpolator
  // ----------------------------------------------------------------
  // The system clock stands for the highest multiplier, so lower ones divide it down.
  logic [2:0]                     div_cnt;
  logic                           phase, sign_ph;
  logic [TIP_SAMPLE_W-1:0]        sr [TIP_TAPS];
  logic signed [TIP_ACC_W-1:0]    acc;
  logic [5:0]                     zero_run;

  wire [2:0]  div_last = 3'((4'd8 >> mult_code) - 4'd1);         // RL6
  // Comparing with >= lets a new multiplier take effect at once instead of wrapping the counter.
  wire        tick     = (div_cnt >= div_last);                  // RL6
  assign      pop      = tick & pop_valid & (~interp_on | ~phase); // RL7 RL8
  wire [TIP_SAMPLE_W-1:0] x_pop = pop ? pop_data : '0;
  wire [TIP_SAMPLE_W-1:0] x_in  = (interp_on && phase) ? '0 : x_pop; // RL1
  wire signed [TIP_SAMPLE_W-1:0] lp_out  = sat(acc >>> TIP_SHIFT);
  wire signed [TIP_SAMPLE_W-1:0] neg_lp  = sat(-(TIP_ACC_W'(lp_out)));
  wire [TIP_SAMPLE_W-1:0] next_code = !interp_on ? x_pop :       // RL3
                                      (is_bp && sign_ph) ? neg_lp : lp_out; // RL10

  always_comb
  begin
    acc = '0;
    for (int k = 0; k < TIP_TAPS; k++)
      acc = acc + TIP_ACC_W'(signed'(sr[k]) * coef(k)); // RL4 RL5
  end

  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_SRST || tick)
      div_cnt <= '0;
    else
      div_cnt <= div_cnt + 3'd1;
  end

  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_SRST)
    begin
      phase <= 1'b0; sign_ph <= 1'b0; O_DAC_UPDATE <= 1'b0; O_DAC_CODE <= '0; zero_run <= '0;
      for (int k = 0; k < TIP_TAPS; k++)
        sr[k] <= '0;
    end
    else
    begin
      O_DAC_UPDATE <= tick;
      if (tick)
      begin
        phase      <= ~phase;
        sign_ph    <= ~sign_ph; // RL10
        O_DAC_CODE <= next_code;
        sr[0]      <= x_in;
        for (int k = 1; k < TIP_TAPS; k++)
          sr[k] <= sr[k-1];
        zero_run <= (x_in != '0) ? 6'd0 : (zero_run == 6'd63) ? zero_run : zero_run + 6'd1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_SRST);

  logic [5:0] nz_cnt;
  always_comb
  begin
    nz_cnt = '0;
    for (int k = 0; k < TIP_TAPS; k++)
      nz_cnt = nz_cnt + 6'(sr[k] != '0);
  end
  wire lone_peak = (nz_cnt == 6'd1) && (sr[TIP_PEAK_TAP] != '0);
  wire [3:0] wr_mode = frame.data[TIP_MODE_MSB:TIP_MODE_LSB];

  mode_decode_a: assert property (wr_commit && frame.addr == TIP_ADDR_FILTER_CTRL |=> // RL2
    interp_on == ($past(wr_mode) == TIP_MODE_LOWPASS || $past(wr_mode) == TIP_MODE_BANDPASS))
    else $error("Mode decode wrong");
  zero_stuff_a: assert property (interp_on && tick && phase |-> !pop && x_in == '0) // RL1
    else $error("Sample taken on a stuffed phase");
  pass_through_a: assert property (!interp_on && tick |=> O_DAC_CODE == $past(x_pop)) // RL3
    else $error("Pass-through output differs from input");
  peak_at_lat_a: assert property (is_lp && tick && lone_peak // RL4
    |=> O_DAC_CODE == $past(sr[TIP_PEAK_TAP]))
    else $error("Impulse peak not at latency");
  flush_zero_a: assert property (interp_on && zero_run >= 6'(TIP_FLUSH) |-> O_DAC_CODE == '0) // RL5
    else $error("Output not flushed to zero");
  rate_div8_a: assert property (tick && mult_code == 2'd0 ##1 (mult_code == 2'd0)[*8] // RL6
    |-> tick && div_cnt == 3'd7)
    else $error("Update strobe rate wrong for multiplier one");
  rate_div1_a: assert property (mult_code == 2'd3 && $past(mult_code) == 2'd3 |-> tick) // RL6
    else $error("Update strobe missing at full rate");
  bp_sign_a: assert property (is_bp && tick && sign_ph |=> O_DAC_CODE == $past(neg_lp)) // RL10
    else $error("Band-pass sign not inverted");
  pop_rate_a: assert property (interp_on && pop |=> !pop) // RL7
    else $error("Two samples taken in one interpolation pair");

  lowpass_run_c: cover property (is_lp && tick && pop ##2 tick && pop);
  bandpass_run_c: cover property (is_bp && tick && sign_ph && O_DAC_CODE != '0);
  bypass_run_c: cover property (!interp_on && pop ##1 pop);
  reg_write_c: cover property (wr_commit && frame.addr == TIP_ADDR_FILTER_CTRL);
endmodule : tip_tx_path

//--- tip_host_model.sv
// Host sample source model for the transmit interpolation path.
`timescale 1ns/100ps
module tip_host_model
  import tip_pkg::*;
(
  input  wire logic                    i_go,
  input  wire logic [TIP_SAMPLE_W-1:0] i_word,
  output      logic                    o_clk,
  output      logic                    o_en,
  output      logic [TIP_SAMPLE_W-1:0] o_data
);
  // ----------------------------------------------------------------
  // Link clock and sample launch
  // ----------------------------------------------------------------
  // The odd start offset keeps link edges off the system clock edges.
  initial
  begin
    o_clk  = 1'b0;
    o_en   = 1'b0;
    o_data = '0;
    #7.3;
    forever #15 o_clk = ~o_clk;
  end

  // Idle data inverts every bit on each link clock so a stale sample never looks valid.
  always @(posedge o_clk)
  begin
    o_en   <= #1 i_go;
    o_data <= #1 i_go ? i_word : ~o_data;
  end
endmodule : tip_host_model

//--- test_tip_tx_path.sv
// Self-checking testbench for the transmit interpolation path.
`timescale 1ns/100ps
module test_tip_tx_path
  import tip_pkg::*;
  ();
  // ----------------------------------------------------------------
  // Bench signals, rows and instances
  // ----------------------------------------------------------------
  typedef struct {logic [3:0] mode; logic [1:0] mult; int period; logic interp;} tip_row_s;
  tip_row_s rows [4] = '{'{4'h1, 2'h0, 8, 1'b1}, '{4'h5, 2'h1, 4, 1'b1},
                         '{4'h0, 2'h2, 2, 1'b0}, '{4'h3, 2'h3, 1, 1'b0}};
  logic                    clk, srst, go, en_n, sclk, sdata, sdo, rdy, upd, lclk, len;
  logic [TIP_SAMPLE_W-1:0] word, ldata, code;
  logic [7:0]              rd;
  logic [3:0]              imodes [3] = '{4'h0, 4'h1, 4'h5};
  int                      n_errors, checked, c, p, q, mx, p0;

  tip_host_model HOST (.i_go(go), .i_word(word), .o_clk(lclk), .o_en(len), .o_data(ldata));
  tip_tx_path DUT (.I_CLK_SYS(clk), .I_SRST(srst), .I_TX_SAMPLE_CLOCK(lclk), .I_TX_ENABLE(len),
    .I_SHARED_SAMPLE_PORT(ldata), .I_SER_EN_N(en_n), .I_SER_SCLK(sclk), .I_SER_SDATA(sdata),
    .O_SER_SDO(sdo), .O_TX_READY(rdy), .O_DAC_UPDATE(upd), .O_DAC_CODE(code));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic ser(input logic r, input logic [6:0] a, input logic [7:0] d);
    tip_frame_s f;
    f = '{rd: r, addr: a, data: d};
    en_n = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      sdata = f[i];
      repeat (6) @(negedge clk);
      if (i < 8)
        rd[i] = sdo;
      sclk = 1'b1;
      repeat (6) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (6) @(negedge clk);
    en_n = 1'b1;
    sdata = ~sdata;
    repeat (8) @(negedge clk);
  endtask : ser

  task automatic period(output int n);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end while (upd !== 1'b1 && n < 40);
  endtask : period

  // Sends one impulse; pk is the update of the peak, last the last non-zero update.
  task automatic imp(output int pk, output int last, output int mag);
    int n;
    int a;
    logic signed [TIP_SAMPLE_W-1:0] v;
    n = 0;
    pk = -1;
    last = -1;
    mag = 0;
    word = 10'h100;
    go = 1'b1;
    @(posedge len);
    @(negedge clk);
    go = 1'b0;
    while (n < 120)
    begin
      if (upd === 1'b1)
      begin
        n++;
        v = code;
        a = (v < 0) ? -int'(v) : int'(v);
        if (a > mag)
        begin
          mag = a;
          pk = n;
        end
        if (v !== '0)
          last = n;
      end
      @(negedge clk);
    end
  endtask : imp

  task automatic conclude();
    if (n_errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // The whole sequence needs well under a third of this span.
  initial
  begin
    #300us;
    n_errors++;
    conclude();
  end

  initial
  begin
    {srst, go, sclk, sdata} = 4'h8;
    en_n = 1'b1;
    word = '0;
    n_errors = 0;
    checked = 0;
    rd = '0;
    repeat (10) @(negedge clk);
    chk(upd, 1'b0);
    chk(rdy, 1'b0);
    repeat (10) @(negedge clk);
    srst = 1'b0;
    repeat (20) @(negedge clk);
    ser(1'b1, TIP_ADDR_FILTER_CTRL, 8'h00);
    chk(rd, TIP_RST_FILTER_CTRL);
    ser(1'b1, TIP_ADDR_CLK_MULT, 8'h00);
    chk(rd[1:0], TIP_RST_CLK_MULT);
    ser(1'b0, 7'h7f, 8'h5a);
    ser(1'b1, 7'h7f, 8'h00);
    chk(rd, 8'h00);
    foreach (rows[i])
    begin
      ser(1'b0, TIP_ADDR_FILTER_CTRL, {rows[i].mode, 4'h0});
      ser(1'b0, TIP_ADDR_CLK_MULT, {6'h00, rows[i].mult});
      ser(1'b1, TIP_ADDR_FILTER_CTRL, 8'h00);
      chk(rd, {rows[i].mode, 4'h0});
      ser(1'b1, TIP_ADDR_STATUS, 8'h00);
      chk(rd[3:1], {rows[i].mult, rows[i].interp});
      period(c);
      period(c);
      chk(c, rows[i].period);
    end
    foreach (imodes[i])
    begin
      ser(1'b0, TIP_ADDR_FILTER_CTRL, {imodes[i], 4'h0});
      repeat (200) @(negedge clk);
      imp(p, q, mx);
      chk(mx, 256);
      if (imodes[i] == 4'h0)
      begin
        p0 = p;
        chk(p <= 20, 1'b1);
        chk(q, p);
      end
      else
      begin
        chk(p - p0 == TIP_LATENCY || p - p0 == TIP_LATENCY + 1, 1'b1);
        chk(q - p < TIP_FLUSH - TIP_LATENCY, 1'b1);
      end
    end
    ser(1'b0, TIP_ADDR_CLK_MULT, 8'h00);
    word = 10'h055;
    go = 1'b1;
    c = 0;
    while (rdy === 1'b1 && c < 400)
    begin
      @(negedge clk);
      c++;
    end
    chk(rdy, 1'b0);
    go = 1'b0;
    repeat (400) @(negedge clk);
    chk(rdy, 1'b1);
    ser(1'b1, TIP_ADDR_STATUS, 8'h00);
    chk(rd[0], 1'b1);
    conclude();
  end
endmodule : test_tip_tx_path
